/* File: sor_pkg.sv */
// constants shared by the reference output state register bank
package sor_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int SOR_NUM_REFS = 8;
	localparam int SOR_DLY_PS_W = 11;

	// ------------------------------------------------------------
	// register offsets, channel order a0 a1 a2 b0 b1 c0 c1 d
	// ------------------------------------------------------------
	localparam logic [7:0] SOR_DLY_OFS [SOR_NUM_REFS] = '{
		8'h28, 8'h29, 8'h2A, 8'h38, 8'h39, 8'h48, 8'h49, 8'h58};
	localparam logic [7:0] SOR_FMT_OFS [SOR_NUM_REFS] = '{
		8'h2C, 8'h2D, 8'h2E, 8'h3C, 8'h3D, 8'h4C, 8'h4D, 8'h5C};
	localparam logic [7:0] SOR_ENA_OFS = 8'h76;

	// ------------------------------------------------------------
	// delay select register fields
	// ------------------------------------------------------------
	localparam int SOR_DLY_FINE_LO_POS = 5;
	localparam int SOR_DLY_SRC_POS = 4;
	localparam int SOR_DLY_COARSE_POS = 1;
	localparam int SOR_DLY_FINE_HI_POS = 0;
	localparam logic [7:0] SOR_DLY_WMASK = 8'h7F;
	localparam logic [7:0] SOR_DLY_RST = 8'h10;

	// ------------------------------------------------------------
	// output format register fields
	// ------------------------------------------------------------
	localparam int SOR_FMT_PD_POS = 7;
	localparam int SOR_FMT_BIAS_POS = 5;
	localparam int SOR_FMT_STYLE_POS = 4;
	localparam int SOR_FMT_AMP_POS = 2;
	localparam logic [7:0] SOR_FMT_WMASK = 8'hBC;
	localparam logic [7:0] SOR_FMT_RST = 8'h00;

	// ------------------------------------------------------------
	// enable register
	// ------------------------------------------------------------
	localparam logic [7:0] SOR_ENA_RST = 8'h00;
	localparam logic [7:0] SOR_RD_UNMAPPED = 8'h00;

	// ------------------------------------------------------------
	// delay steps in ps
	// ------------------------------------------------------------
	localparam logic [SOR_DLY_PS_W-1:0] SOR_COARSE_STEP_PS = 11'h0A9;
	localparam logic [SOR_DLY_PS_W-1:0] SOR_FINE_PS [8] = '{
		11'h000, 11'h019, 11'h032, 11'h04B, 11'h055, 11'h06E, 11'h087, 11'h0A0};

endpackage : sor_pkg

/* File: sor_ref_chan.sv */
// one reference output: its two registers, source mux and delay decode
`timescale 1ns/1ps
`default_nettype none

module sor_ref_chan
	import sor_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// register writes
	input wire logic dly_wr,
	input wire logic fmt_wr,
	input wire logic [7:0] wdata,
	// signal sources
	input wire logic chan_clk,
	input wire logic sysref_in,
	// register contents
	output logic [7:0] dly_q,
	output logic [7:0] fmt_q,
	// derived controls
	output logic [SOR_DLY_PS_W-1:0] delay_ps_q,
	output logic ref_out_q
);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic [7:0] dly_d;
	logic [7:0] fmt_d;
	logic [SOR_DLY_PS_W-1:0] delay_ps_d;
	logic ref_out_d;
	logic [2:0] coarse;
	logic [2:0] fine;

	always_comb begin
		dly_d = dly_q;
		fmt_d = fmt_q;
		// reserved bits stay zero whatever is written
		if (dly_wr) begin
			dly_d = wdata & SOR_DLY_WMASK;
		end
		if (fmt_wr) begin
			fmt_d = wdata & SOR_FMT_WMASK;
		end
		coarse = dly_q[SOR_DLY_COARSE_POS +: 3];
		fine = {dly_q[SOR_DLY_FINE_HI_POS], dly_q[SOR_DLY_FINE_LO_POS +: 2]};
		// fine steps are not uniform, hence the table
		delay_ps_d = SOR_DLY_PS_W'(coarse * SOR_COARSE_STEP_PS) + SOR_FINE_PS[fine];
		ref_out_d = dly_q[SOR_DLY_SRC_POS] ? sysref_in : chan_clk;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			dly_q <= SOR_DLY_RST;
			fmt_q <= SOR_FMT_RST;
			delay_ps_q <= '0;
			ref_out_q <= 1'b0;
		end else begin
			dly_q <= dly_d;
			fmt_q <= fmt_d;
			delay_ps_q <= delay_ps_d;
			ref_out_q <= ref_out_d;
		end
	end

endmodule : sor_ref_chan

`default_nettype wire

/* File: sor_regs.sv */
// reference output state register bank, eight outputs
`timescale 1ns/1ps
`default_nettype none

module sor_regs
	import sor_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// register access from the serial configuration port
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	output logic [7:0] cfg_rdata_q,
	output logic cfg_rvalid_q,
	// signal sources
	input wire logic [SOR_NUM_REFS-1:0] chan_clk,
	input wire logic sysref_in,
	// per output controls
	output logic [SOR_NUM_REFS-1:0] ref_out_q,
	output logic [SOR_NUM_REFS-1:0] ref_source_select,
	output logic [SOR_NUM_REFS-1:0][2:0] ref_coarse_delay,
	output logic [SOR_NUM_REFS-1:0][2:0] ref_fine_delay,
	output logic [SOR_NUM_REFS-1:0][SOR_DLY_PS_W-1:0] ref_delay_ps_q,
	output logic [SOR_NUM_REFS-1:0] ref_power_down,
	output logic [SOR_NUM_REFS-1:0] ref_bias_select,
	output logic [SOR_NUM_REFS-1:0] ref_style,
	output logic [SOR_NUM_REFS-1:0][1:0] ref_amplitude,
	output logic [SOR_NUM_REFS-1:0] ref_out_enable_bit
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	logic [SOR_NUM_REFS-1:0] dly_hit;
	logic [SOR_NUM_REFS-1:0] fmt_hit;
	logic ena_hit;
	// register contents, held in the output slices and the enable flops
	logic [7:0] dly_q [SOR_NUM_REFS];
	logic [7:0] fmt_q [SOR_NUM_REFS];
	logic [7:0] ena_q;

	// one hit line per register; an unmapped address hits nothing
	always_comb begin
		dly_hit = '0;
		fmt_hit = '0;
		ena_hit = 1'b0;
		case (cfg_addr)
			// delay select registers
			SOR_DLY_OFS[0]: begin
				dly_hit[0] = 1'b1;
			end
			SOR_DLY_OFS[1]: begin
				dly_hit[1] = 1'b1;
			end
			SOR_DLY_OFS[2]: begin
				dly_hit[2] = 1'b1;
			end
			SOR_DLY_OFS[3]: begin
				dly_hit[3] = 1'b1;
			end
			SOR_DLY_OFS[4]: begin
				dly_hit[4] = 1'b1;
			end
			SOR_DLY_OFS[5]: begin
				dly_hit[5] = 1'b1;
			end
			SOR_DLY_OFS[6]: begin
				dly_hit[6] = 1'b1;
			end
			SOR_DLY_OFS[7]: begin
				dly_hit[7] = 1'b1;
			end
			// output format registers
			SOR_FMT_OFS[0]: begin
				fmt_hit[0] = 1'b1;
			end
			SOR_FMT_OFS[1]: begin
				fmt_hit[1] = 1'b1;
			end
			SOR_FMT_OFS[2]: begin
				fmt_hit[2] = 1'b1;
			end
			SOR_FMT_OFS[3]: begin
				fmt_hit[3] = 1'b1;
			end
			SOR_FMT_OFS[4]: begin
				fmt_hit[4] = 1'b1;
			end
			SOR_FMT_OFS[5]: begin
				fmt_hit[5] = 1'b1;
			end
			SOR_FMT_OFS[6]: begin
				fmt_hit[6] = 1'b1;
			end
			SOR_FMT_OFS[7]: begin
				fmt_hit[7] = 1'b1;
			end
			// shared enable register
			SOR_ENA_OFS: begin
				ena_hit = 1'b1;
			end
			default: begin
				ena_hit = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// write strobes
	// ------------------------------------------------------------
	logic [SOR_NUM_REFS-1:0] dly_wr;
	logic [SOR_NUM_REFS-1:0] fmt_wr;
	logic ena_wr;

	// a write lands on the edge that takes it; a read in that cycle sees the old value
	always_comb begin
		dly_wr = '0;
		fmt_wr = '0;
		ena_wr = 1'b0;
		if (cfg_wr) begin
			dly_wr = dly_hit;
			fmt_wr = fmt_hit;
			ena_wr = ena_hit;
		end
	end

	// ------------------------------------------------------------
	// per output registers
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < SOR_NUM_REFS; g++) begin : g_ref
			sor_ref_chan u_chan (
				.sys_clk(sys_clk),
				.nrst(nrst),
				.dly_wr(dly_wr[g]),
				.fmt_wr(fmt_wr[g]),
				.wdata(cfg_wdata),
				.chan_clk(chan_clk[g]),
				.sysref_in(sysref_in),
				.dly_q(dly_q[g]),
				.fmt_q(fmt_q[g]),
				.delay_ps_q(ref_delay_ps_q[g]),
				.ref_out_q(ref_out_q[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// delay select fields, straight off the register flops
	// ------------------------------------------------------------
	// the fine code is split: its msb sits at bit 0, below the coarse field
	generate
		for (g = 0; g < SOR_NUM_REFS; g++) begin : g_dly
			assign ref_source_select[g] = dly_q[g][SOR_DLY_SRC_POS];
			assign ref_coarse_delay[g] = dly_q[g][SOR_DLY_COARSE_POS +: 3];
			assign ref_fine_delay[g] = {dly_q[g][SOR_DLY_FINE_HI_POS],
				dly_q[g][SOR_DLY_FINE_LO_POS +: 2]};
		end
	endgenerate

	// ------------------------------------------------------------
	// output format fields
	// ------------------------------------------------------------
	// these only steer the output stage; nothing in this block reads them
	generate
		for (g = 0; g < SOR_NUM_REFS; g++) begin : g_fmt
			assign ref_power_down[g] = fmt_q[g][SOR_FMT_PD_POS];
			assign ref_bias_select[g] = fmt_q[g][SOR_FMT_BIAS_POS];
			assign ref_style[g] = fmt_q[g][SOR_FMT_STYLE_POS];
			assign ref_amplitude[g] = fmt_q[g][SOR_FMT_AMP_POS +: 2];
		end
	endgenerate

	// ------------------------------------------------------------
	// enable bits
	// ------------------------------------------------------------
	// the enable register is msb first: bit 7 is output a0
	generate
		for (g = 0; g < SOR_NUM_REFS; g++) begin : g_ena
			assign ref_out_enable_bit[g] = ena_q[SOR_NUM_REFS-1-g];
		end
	endgenerate

	// ------------------------------------------------------------
	// enable register
	// ------------------------------------------------------------
	logic [7:0] ena_d;

	// all eight bits are writable, so no mask
	always_comb begin
		ena_d = ena_q;
		if (ena_wr) begin
			ena_d = cfg_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ena_q <= SOR_ENA_RST;
		end else begin
			ena_q <= ena_d;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	logic [7:0] cfg_rdata_d;
	logic cfg_rvalid_d;

	// read data stand until the next read, so software may take them late
	always_comb begin
		cfg_rdata_d = cfg_rdata_q;
		cfg_rvalid_d = cfg_rd;
		// a read has no side effect on any register
		if (cfg_rd) begin
			case (cfg_addr)
				// delay select registers
				SOR_DLY_OFS[0]: begin
					cfg_rdata_d = dly_q[0];
				end
				SOR_DLY_OFS[1]: begin
					cfg_rdata_d = dly_q[1];
				end
				SOR_DLY_OFS[2]: begin
					cfg_rdata_d = dly_q[2];
				end
				SOR_DLY_OFS[3]: begin
					cfg_rdata_d = dly_q[3];
				end
				SOR_DLY_OFS[4]: begin
					cfg_rdata_d = dly_q[4];
				end
				SOR_DLY_OFS[5]: begin
					cfg_rdata_d = dly_q[5];
				end
				SOR_DLY_OFS[6]: begin
					cfg_rdata_d = dly_q[6];
				end
				SOR_DLY_OFS[7]: begin
					cfg_rdata_d = dly_q[7];
				end
				// output format registers
				SOR_FMT_OFS[0]: begin
					cfg_rdata_d = fmt_q[0];
				end
				SOR_FMT_OFS[1]: begin
					cfg_rdata_d = fmt_q[1];
				end
				SOR_FMT_OFS[2]: begin
					cfg_rdata_d = fmt_q[2];
				end
				SOR_FMT_OFS[3]: begin
					cfg_rdata_d = fmt_q[3];
				end
				SOR_FMT_OFS[4]: begin
					cfg_rdata_d = fmt_q[4];
				end
				SOR_FMT_OFS[5]: begin
					cfg_rdata_d = fmt_q[5];
				end
				SOR_FMT_OFS[6]: begin
					cfg_rdata_d = fmt_q[6];
				end
				SOR_FMT_OFS[7]: begin
					cfg_rdata_d = fmt_q[7];
				end
				// shared enable register
				SOR_ENA_OFS: begin
					cfg_rdata_d = ena_q;
				end
				// unmapped addresses read as zero
				default: begin
					cfg_rdata_d = SOR_RD_UNMAPPED;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_rdata_q <= SOR_RD_UNMAPPED;
			cfg_rvalid_q <= 1'b0;
		end else begin
			cfg_rdata_q <= cfg_rdata_d;
			cfg_rvalid_q <= cfg_rvalid_d;
		end
	end

endmodule : sor_regs

`default_nettype wire

/* File: sor_regs_asserts.sv */
// concurrent checks on the reference output register bank ports
`timescale 1ns/1ps
`default_nettype none
module sor_regs_asserts
	import sor_pkg::*;
(
	// watched ports
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_rdata_q,
	input wire logic cfg_rvalid_q,
	input wire logic [SOR_NUM_REFS-1:0] chan_clk,
	input wire logic sysref_in,
	input wire logic [SOR_NUM_REFS-1:0] ref_out_q,
	input wire logic [SOR_NUM_REFS-1:0] ref_source_select,
	input wire logic [SOR_NUM_REFS-1:0][2:0] ref_coarse_delay,
	input wire logic [SOR_NUM_REFS-1:0][2:0] ref_fine_delay,
	input wire logic [SOR_NUM_REFS-1:0][SOR_DLY_PS_W-1:0] ref_delay_ps_q
);
	// ------------------------------------------------------------
	// properties, checked on output a0 to keep the unroll small; the two reset checks cover all eight outputs
	// ------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	wire logic wr_a0 = cfg_wr && cfg_addr == 8'h28;
	mux_sysref_a: assert property (ref_source_select[0] |=> ref_out_q[0] == $past(sysref_in))
		else $error("a0 does not follow sysref");
	mux_chan_a: assert property (!ref_source_select[0] |=> ref_out_q[0] == $past(chan_clk[0]))
		else $error("a0 does not follow its channel clock");
	src_write_a: assert property (wr_a0 |=> ref_source_select[0] == $past(cfg_wdata[4]))
		else $error("source bit not taken from write");
	rst_source_a: assert property ($rose(nrst) |-> ref_source_select == 8'hFF)
		else $error("source bits not 1 after reset");
	rst_coarse_a: assert property ($rose(nrst) |-> ref_coarse_delay == 24'h000000)
		else $error("coarse delay not 0 after reset");
	coarse_write_a: assert property (wr_a0 |=> ref_coarse_delay[0] == $past(cfg_wdata[3:1]))
		else $error("coarse field misplaced");
	fine_write_a: assert property (wr_a0 |=> ref_fine_delay[0] == {$past(cfg_wdata[0]), $past(cfg_wdata[6:5])})
		else $error("fine field misplaced");
	delay_sum_a: assert property (##1 ref_delay_ps_q[0] == $past(ref_coarse_delay[0]) * 11'h0A9 + SOR_FINE_PS[$past(ref_fine_delay[0])])
		else $error("delay in ps wrong");
	rsv_dly_a: assert property (cfg_rd && cfg_addr == 8'h28 |=> cfg_rvalid_q && !cfg_rdata_q[7])
		else $error("reserved delay bit reads 1");
	rsv_fmt_a: assert property (cfg_rd && cfg_addr == 8'h2C |=> cfg_rvalid_q && cfg_rdata_q[6] == 1'b0 && cfg_rdata_q[1:0] == 2'h0)
		else $error("reserved format bits read 1");
	cov_wr_c: cover property (wr_a0 ##2 ref_delay_ps_q[0] != 11'h000);
	cov_chan_c: cover property (!ref_source_select[0] ##1 ref_out_q[0]);
	cov_rd_c: cover property (cfg_rd ##1 cfg_rvalid_q);
endmodule : sor_regs_asserts
bind sor_regs sor_regs_asserts u_chk (.sys_clk, .nrst, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd,
	.cfg_rdata_q, .cfg_rvalid_q, .chan_clk, .sysref_in, .ref_out_q, .ref_source_select,
	.ref_coarse_delay, .ref_fine_delay, .ref_delay_ps_q);
`default_nettype wire

/* File: sor_regs_tb.sv */
// self-checking bench for the reference output register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module sor_regs_tb;
	import sor_pkg::*;
	// ------------------------------------------------------------
	// stimulus and wiring
	// ------------------------------------------------------------
	logic sys_clk = 0, nrst = 0, cfg_wr = 0, cfg_rd = 0, sysref_in = 0;
	logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata_q, cfg_rvalid_q, chan_clk = 8'h00;
	logic [7:0] ref_out_q, src, pd, bias, sty, ena;
	logic [7:0][2:0] crs, fin;
	logic [7:0][10:0] dps;
	logic [7:0][1:0] amp;
	logic [2:0] c, f;
	int error_cnt = 0, tests_run = 0;
	// fine steps kept here so the bench does not lean on the package table
	logic [10:0] ft [8] = '{11'h000, 11'h019, 11'h032, 11'h04B, 11'h055, 11'h06E, 11'h087, 11'h0A0};
	always #2 sys_clk = ~sys_clk;
	sor_regs DUT (.sys_clk(sys_clk), .nrst(nrst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q),
		.chan_clk(chan_clk), .sysref_in(sysref_in), .ref_out_q(ref_out_q), .ref_source_select(src),
		.ref_coarse_delay(crs), .ref_fine_delay(fin), .ref_delay_ps_q(dps), .ref_power_down(pd),
		.ref_bias_select(bias), .ref_style(sty), .ref_amplitude(amp), .ref_out_enable_bit(ena));
	// ------------------------------------------------------------
	// access tasks; a spare cycle after each keeps strobes single-driven
	// ------------------------------------------------------------
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) begin cfg_wr <= 1'b1; cfg_addr <= a; cfg_wdata <= d; end
		@(posedge sys_clk) cfg_wr <= 1'b0;
		@(posedge sys_clk) #1;
	endtask : wr
	task rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk) begin cfg_rd <= 1'b1; cfg_addr <= a; end
		@(posedge sys_clk) cfg_rd <= 1'b0;
		#1 `CHK(cfg_rvalid_q, 1'b1)
		`CHK(cfg_rdata_q, e)
		@(posedge sys_clk) #1 `CHK(cfg_rvalid_q, 1'b0)
	endtask : rdc
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		`CHK(src, 8'hFF)
		`CHK(crs, 24'h000000)
		`CHK(dps[0], 11'h000)
		for (int i = 0; i < 8; i++) begin
			rdc(SOR_DLY_OFS[i], 8'h10);
			rdc(SOR_FMT_OFS[i], 8'h00);
			wr(SOR_DLY_OFS[i], 8'hFF);
			rdc(SOR_DLY_OFS[i], 8'h7F);
			`CHK(dps[i], 11'h53F)
			wr(SOR_FMT_OFS[i], 8'hFF);
			rdc(SOR_FMT_OFS[i], 8'hBC);
		end
		`CHK({pd, bias, sty, amp}, 40'hFFFFFFFFFF)
		wr(8'h76, 8'h80);
		`CHK(ena, 8'h01)
		rdc(8'h76, 8'h80);
		wr(8'h30, 8'hFF);
		rdc(8'h30, 8'h00);
		for (int k = 0; k < 8; k++) begin
			c = k[2:0];
			f = ~c;
			wr(8'h28, {1'b0, f[1:0], 1'b0, c, f[2]});
			`CHK(dps[0], c * 11'h0A9 + ft[f])
			`CHK(crs[0], c)
			`CHK(fin[0], f)
		end
		// a0 now takes its channel clock, the rest still sysref
		`CHK(src, 8'hFE)
		@(posedge sys_clk) begin chan_clk <= 8'h01; sysref_in <= 1'b0; end
		@(posedge sys_clk) #1 `CHK(ref_out_q, 8'h01)
		@(posedge sys_clk) begin chan_clk <= 8'h00; sysref_in <= 1'b1; end
		@(posedge sys_clk) #1 `CHK(ref_out_q, 8'hFE)
		print_verdict;
	end
	initial begin
		#20000 error_cnt++;
		print_verdict;
	end
endmodule : sor_regs_tb
`undef CHK
`default_nettype wire
